/* File: src/pmd_pkg.sv */
// Package for the peripheral module disable bank: offsets, field positions, masks, resets.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package pmd_pkg;
  localparam logic [7:0] PMD_OFS_CTRL_1 = 8'h00;
  localparam logic [7:0] PMD_OFS_CTRL_2 = 8'h04;
  localparam logic [7:0] PMD_OFS_CTRL_3 = 8'h08;
  localparam logic [7:0] PMD_OFS_CTRL_4 = 8'h0C;
  localparam logic [7:0] PMD_OFS_CTRL_6 = 8'h14;
  localparam logic [7:0] PMD_OFS_CTRL_7 = 8'h18;
  localparam logic [7:0] PMD_OFS_CTRL_8 = 8'h1C;
  // Writable masks of the implemented bits.
  localparam logic [15:0] PMD_MASK_1 = 16'h000B;
  localparam logic [15:0] PMD_MASK_2 = 16'h0F0F;
  localparam logic [15:0] PMD_MASK_3 = 16'h0400;
  localparam logic [15:0] PMD_MASK_4 = 16'h000C;
  localparam logic [15:0] PMD_MASK_6 = 16'h0700;
  localparam logic [15:0] PMD_MASK_7 = 16'h0010;
  localparam logic [15:0] PMD_MASK_8 = 16'h1900;
  localparam logic [15:0] PMD_RESET = 16'h0000;
  // Field positions.
  localparam int PMD_ADC_BIT = 0;
  localparam int PMD_CAN_BIT = 1;
  localparam int PMD_SPI_BIT = 3;
  localparam int PMD_CAP_LSB = 8;
  localparam int PMD_CMP_LSB = 0;
  localparam int PMD_CMPR_BIT = 10;
  localparam int PMD_CTMU_BIT = 2;
  localparam int PMD_REFO_BIT = 3;
  localparam int PMD_PWM_LSB = 8;
  localparam int PMD_DMA_BIT = 4;
  localparam int PMD_DMT_BIT = 8;
  localparam int PMD_SENTA_BIT = 11;
  localparam int PMD_SENTB_BIT = 12;
  localparam logic [1:0] PMD_RESP_OKAY = 2'b00;
  localparam logic [1:0] PMD_RESP_SLVERR = 2'b10;
endpackage

/* File: src/pmd_bank.sv */
// Peripheral module disable bank with AXI4-Lite slave, per-unit enables, and clock gates for all units but PWM and SENT.
// Assumes CLOCK is the system clock at 20 MHz and RSTN an asynchronous active-low reset.
`timescale 1ns/100ps
module pmd_bank
  import pmd_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1
)
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic ADC_EN,
  output logic CAN_EN,
  output logic SPI_EN,
  output logic [3:0] CAPTURE_EN,
  output logic [3:0] COMPARE_EN,
  output logic COMPARATOR_EN,
  output logic REFCLK_EN,
  output logic CTMU_EN,
  output logic [2:0] PWM_EN,
  output logic DMA_EN,
  output logic DEADMAN_EN,
  output logic SENT_A_EN,
  output logic SENT_B_EN,
  output logic [15:0] UNIT_CLK_GATE,
  input wire logic [15:0] UNIT_SEL_IN,
  output logic [15:0] UNIT_SEL_OUT
);

  // Unit enable vector order: adc, can, spi, cap[4], cmp[4], cmpr, refo, ctmu, dma, deadman.
  // Only sixteen bits of gating are exported; the remaining units share their enable port.

  typedef struct packed {
    logic [15:0] ctrl_1;
    logic [15:0] ctrl_2;
    logic [15:0] ctrl_3;
    logic [15:0] ctrl_4;
    logic [15:0] ctrl_6;
    logic [15:0] ctrl_7;
    logic [15:0] ctrl_8;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] gate;
  } pmd_state_s;

  pmd_state_s st_r;
  pmd_state_s st_nxt;
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  // Reset release is synchronised so every register leaves reset on the same edge.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // Reads a register by byte offset; unmapped offsets flag an error.
  function automatic logic [16:0] read_reg(input pmd_state_s s, input logic [7:0] a);
    logic [16:0] r;
    r = {1'b0, 16'h0000};
    if (a == PMD_OFS_CTRL_1) r = {1'b1, s.ctrl_1};
    else if (a == PMD_OFS_CTRL_2) r = {1'b1, s.ctrl_2};
    else if (a == PMD_OFS_CTRL_3) r = {1'b1, s.ctrl_3};
    else if (a == PMD_OFS_CTRL_4) r = {1'b1, s.ctrl_4};
    else if (a == PMD_OFS_CTRL_6) r = {1'b1, s.ctrl_6};
    else if (a == PMD_OFS_CTRL_7) r = {1'b1, s.ctrl_7};
    else if (a == PMD_OFS_CTRL_8) r = {1'b1, s.ctrl_8};
    return r;
  endfunction

  // Merges byte-enabled write data into the implemented bits only.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be, input logic [15:0] m);
    logic [15:0] bm;
    bm = {{8{be[1]}}, {8{be[0]}}} & m;
    return (old & ~bm) | (d[15:0] & bm);
  endfunction

  logic [15:0] mask_1;
  assign mask_1 = HAS_CAN ? PMD_MASK_1 : (PMD_MASK_1 & ~16'h0002);

  logic [15:0] en_vec;

  // Next state: bus handshakes, register writes and the registered clock gates.
  always_comb
  begin
    logic [16:0] rd;
    logic do_wr;
    rd = 17'h0_0000;
    do_wr = 1'b0;
    st_nxt = st_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = S_AXI_WDATA;
      st_nxt.w_strb = S_AXI_WSTRB;
    end
    do_wr = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    if (do_wr)
    begin
      rd = read_reg(st_r, st_r.aw_addr);
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = rd[16] ? PMD_RESP_OKAY : PMD_RESP_SLVERR;
      if (st_r.aw_addr == PMD_OFS_CTRL_1)
        st_nxt.ctrl_1 = merge(st_r.ctrl_1, st_r.w_data, st_r.w_strb, mask_1);
      else if (st_r.aw_addr == PMD_OFS_CTRL_2)
        st_nxt.ctrl_2 = merge(st_r.ctrl_2, st_r.w_data, st_r.w_strb, PMD_MASK_2);
      else if (st_r.aw_addr == PMD_OFS_CTRL_3)
        st_nxt.ctrl_3 = merge(st_r.ctrl_3, st_r.w_data, st_r.w_strb, PMD_MASK_3);
      else if (st_r.aw_addr == PMD_OFS_CTRL_4)
        st_nxt.ctrl_4 = merge(st_r.ctrl_4, st_r.w_data, st_r.w_strb, PMD_MASK_4);
      else if (st_r.aw_addr == PMD_OFS_CTRL_6)
        st_nxt.ctrl_6 = merge(st_r.ctrl_6, st_r.w_data, st_r.w_strb, PMD_MASK_6);
      else if (st_r.aw_addr == PMD_OFS_CTRL_7)
        st_nxt.ctrl_7 = merge(st_r.ctrl_7, st_r.w_data, st_r.w_strb, PMD_MASK_7);
      else if (st_r.aw_addr == PMD_OFS_CTRL_8)
        st_nxt.ctrl_8 = merge(st_r.ctrl_8, st_r.w_data, st_r.w_strb, PMD_MASK_8);
    end
    if (st_r.bvalid && S_AXI_BREADY)
      st_nxt.bvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rd = read_reg(st_r, S_AXI_ARADDR);
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = {16'h0000, rd[15:0]};
      st_nxt.rresp = rd[16] ? PMD_RESP_OKAY : PMD_RESP_SLVERR;
    end
    else if (st_r.rvalid && S_AXI_RREADY)
      st_nxt.rvalid = 1'b0;
    // Gates follow the enables one cycle later, as a registered copy.
    st_nxt.gate = en_vec;
  end

  // One state register; all implemented disable bits clear so units start enabled.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.ctrl_1 <= PMD_RESET;
      // Without a CAN unit its gate starts closed, matching its enable from the first edge.
      st_r.gate <= {14'h3FFF, HAS_CAN, 1'b1};
    end
    else
      st_r <= st_nxt;
  end

  // Handshake readies are combinational; each channel takes one item per transaction.
  assign S_AXI_AWREADY = !st_r.aw_held && !st_r.bvalid;
  assign S_AXI_WREADY = !st_r.w_held && !st_r.bvalid;
  assign S_AXI_ARREADY = !st_r.rvalid;
  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP = st_r.bresp;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RDATA = st_r.rdata;
  assign S_AXI_RRESP = st_r.rresp;

  // Enables are the inverse of the registered disable bits, with CAN_EN also needing HAS_CAN.
  assign ADC_EN = !st_r.ctrl_1[PMD_ADC_BIT];
  assign CAN_EN = HAS_CAN && !st_r.ctrl_1[PMD_CAN_BIT];
  assign SPI_EN = !st_r.ctrl_1[PMD_SPI_BIT];
  assign CAPTURE_EN = ~st_r.ctrl_2[PMD_CAP_LSB +: 4];
  assign COMPARE_EN = ~st_r.ctrl_2[PMD_CMP_LSB +: 4];
  assign COMPARATOR_EN = !st_r.ctrl_3[PMD_CMPR_BIT];
  assign REFCLK_EN = !st_r.ctrl_4[PMD_REFO_BIT];
  assign CTMU_EN = !st_r.ctrl_4[PMD_CTMU_BIT];
  assign PWM_EN = ~st_r.ctrl_6[PMD_PWM_LSB +: 3];
  assign DMA_EN = !st_r.ctrl_7[PMD_DMA_BIT];
  assign DEADMAN_EN = !st_r.ctrl_8[PMD_DMT_BIT];
  assign SENT_A_EN = !st_r.ctrl_8[PMD_SENTA_BIT];
  assign SENT_B_EN = !st_r.ctrl_8[PMD_SENTB_BIT];

  // Gate vector: adc, can, spi, cap[3:0], cmp[3:0], cmpr, refo, ctmu, dma, deadman.
  assign en_vec = {DEADMAN_EN, DMA_EN, CTMU_EN, REFCLK_EN, COMPARATOR_EN,
                   COMPARE_EN, CAPTURE_EN, SPI_EN, CAN_EN, ADC_EN};

  // Clock gate enables are registered so they change only on a rising clock edge, avoiding glitches.
  assign UNIT_CLK_GATE = st_r.gate;
  // Register selects of disabled units are blocked so their writes have no effect.
  assign UNIT_SEL_OUT = UNIT_SEL_IN & en_vec;

  // Assertions.
  property p_adc_en;
    @(posedge CLOCK) disable iff (!rst_n) ADC_EN == !st_r.ctrl_1[0];
  endproperty
  a_adc_en: assert property (p_adc_en) else $error("adc enable mismatch");

  property p_can_en;
    @(posedge CLOCK) disable iff (!rst_n) CAN_EN == (HAS_CAN && !st_r.ctrl_1[1]);
  endproperty
  a_can_en: assert property (p_can_en) else $error("can enable mismatch");

  property p_spi_en;
    @(posedge CLOCK) disable iff (!rst_n) SPI_EN == !st_r.ctrl_1[3];
  endproperty
  a_spi_en: assert property (p_spi_en) else $error("spi enable mismatch");

  property p_cap_en;
    @(posedge CLOCK) disable iff (!rst_n) CAPTURE_EN == ~st_r.ctrl_2[11:8];
  endproperty
  a_cap_en: assert property (p_cap_en) else $error("capture enable mismatch");

  property p_cmp_en;
    @(posedge CLOCK) disable iff (!rst_n) COMPARE_EN == ~st_r.ctrl_2[3:0];
  endproperty
  a_cmp_en: assert property (p_cmp_en) else $error("compare enable mismatch");

  property p_cmpr_en;
    @(posedge CLOCK) disable iff (!rst_n) COMPARATOR_EN == !st_r.ctrl_3[10];
  endproperty
  a_cmpr_en: assert property (p_cmpr_en) else $error("comparator enable mismatch");

  property p_refo_en;
    @(posedge CLOCK) disable iff (!rst_n) REFCLK_EN == !st_r.ctrl_4[3];
  endproperty
  a_refo_en: assert property (p_refo_en) else $error("refclk enable mismatch");

  property p_ctmu_en;
    @(posedge CLOCK) disable iff (!rst_n) CTMU_EN == !st_r.ctrl_4[2];
  endproperty
  a_ctmu_en: assert property (p_ctmu_en) else $error("charge unit enable mismatch");

  property p_dmt_sent;
    @(posedge CLOCK) disable iff (!rst_n) {SENT_B_EN, SENT_A_EN, DEADMAN_EN} == ~{st_r.ctrl_8[12:11], st_r.ctrl_8[8]};
  endproperty
  a_dmt_sent: assert property (p_dmt_sent) else $error("deadman or sent enable mismatch");

  property p_can_absent;
    @(posedge CLOCK) disable iff (!rst_n) !HAS_CAN |-> !CAN_EN && !st_r.ctrl_1[1];
  endproperty
  a_can_absent: assert property (p_can_absent) else $error("can present when absent");

  property p_unimpl_zero;
    @(posedge CLOCK) disable iff (!rst_n)
      (st_r.ctrl_2 & ~PMD_MASK_2) == 16'h0000 && (st_r.ctrl_8 & ~PMD_MASK_8) == 16'h0000
      && (st_r.ctrl_3 & ~PMD_MASK_3) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  // The first register's mask is the variant one, so a missing CAN bit must stay clear too.
  property p_unimpl_rest;
    @(posedge CLOCK) disable iff (!rst_n)
      (st_r.ctrl_1 & ~mask_1) == 16'h0000 && (st_r.ctrl_4 & ~PMD_MASK_4) == 16'h0000
      && (st_r.ctrl_6 & ~PMD_MASK_6) == 16'h0000 && (st_r.ctrl_7 & ~PMD_MASK_7) == 16'h0000;
  endproperty
  a_unimpl_rest: assert property (p_unimpl_rest) else $error("unimplemented bit set");

  property p_gate_lag;
    @(posedge CLOCK) disable iff (!rst_n) ##1 UNIT_CLK_GATE == $past(en_vec);
  endproperty
  a_gate_lag: assert property (p_gate_lag) else $error("gate not one cycle late");

  property p_sel_block;
    @(posedge CLOCK) disable iff (!rst_n) !ADC_EN |-> !UNIT_SEL_OUT[0];
  endproperty
  a_sel_block: assert property (p_sel_block) else $error("select passed to off unit");

  property p_sel_all;
    @(posedge CLOCK) disable iff (!rst_n) (UNIT_SEL_OUT & ~en_vec) == 16'h0000;
  endproperty
  a_sel_all: assert property (p_sel_all) else $error("select passed to off unit");

  property p_pwm_en;
    @(posedge CLOCK) disable iff (!rst_n) PWM_EN == ~st_r.ctrl_6[10:8];
  endproperty
  a_pwm_en: assert property (p_pwm_en) else $error("pwm enable mismatch");

  property p_dma_en;
    @(posedge CLOCK) disable iff (!rst_n) DMA_EN != st_r.ctrl_7[4];
  endproperty
  a_dma_en: assert property (p_dma_en) else $error("dma enable mismatch");

  property p_reset_on;
    @(posedge CLOCK) $rose(rst_n) |-> ADC_EN && SPI_EN && (CAPTURE_EN == 4'hF) && DMA_EN;
  endproperty
  a_reset_on: assert property (p_reset_on) else $error("unit off after reset");

  property p_wr_resp;
    @(posedge CLOCK) disable iff (!rst_n)
      st_r.aw_held && st_r.w_held && !st_r.bvalid |=> S_AXI_BVALID;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

  property p_rd_resp;
    @(posedge CLOCK) disable iff (!rst_n) S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");

  // Responses must stand until taken, or a slow master would lose them.
  property p_bvalid_hold;
    @(posedge CLOCK) disable iff (!rst_n) S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_rvalid_hold;
    @(posedge CLOCK) disable iff (!rst_n) S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID;
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");

  c_write: cover property (@(posedge CLOCK) disable iff (!rst_n) S_AXI_BVALID && S_AXI_BREADY);
  c_read: cover property (@(posedge CLOCK) disable iff (!rst_n) S_AXI_RVALID && S_AXI_RREADY);
  c_off: cover property (@(posedge CLOCK) disable iff (!rst_n) $fell(SENT_B_EN));
  c_can_off: cover property (@(posedge CLOCK) disable iff (!rst_n) $fell(CAN_EN));
  c_rd_err: cover property (@(posedge CLOCK) disable iff (!rst_n) S_AXI_RVALID && S_AXI_RRESP[1]);
endmodule

/* File: test/pmd_bank_test.sv */
// Self-checking bench for the peripheral disable bank: AXI4-Lite access and unit enables.
// Assumes pmd_pkg and pmd_bank are compiled first; the bank's own assertions run inside it.
`timescale 1ns/100ps
module pmd_bank_test;
  import pmd_pkg::*;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [15:0] sel_in = 16'hFFFF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic adc, can, spi, cmpr, refc, ctmu, dma, dmt, sa, sb;
  logic [3:0] cap, cmp;
  logic [2:0] pwm;
  logic [15:0] gate, sel_out;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] ofs [7] = '{PMD_OFS_CTRL_1, PMD_OFS_CTRL_2, PMD_OFS_CTRL_3, PMD_OFS_CTRL_4,
    PMD_OFS_CTRL_6, PMD_OFS_CTRL_7, PMD_OFS_CTRL_8};
  logic [15:0] msk [7] = '{PMD_MASK_1, PMD_MASK_2, PMD_MASK_3, PMD_MASK_4, PMD_MASK_6,
    PMD_MASK_7, PMD_MASK_8};
  logic [15:0] shd [7];

  pmd_bank u_dut (.CLOCK(CLOCK), .RSTN(RSTN), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .ADC_EN(adc), .CAN_EN(can), .SPI_EN(spi), .CAPTURE_EN(cap), .COMPARE_EN(cmp),
    .COMPARATOR_EN(cmpr), .REFCLK_EN(refc), .CTMU_EN(ctmu), .PWM_EN(pwm), .DMA_EN(dma),
    .DEADMAN_EN(dmt), .SENT_A_EN(sa), .SENT_B_EN(sb), .UNIT_CLK_GATE(gate),
    .UNIT_SEL_IN(sel_in), .UNIT_SEL_OUT(sel_out));

  // Free-running system clock, 50 ns period.
  always #25 CLOCK = ~CLOCK;

  // Case equality so that an unknown output never counts as a match.
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Enables are checked half a cycle after the response edge, the gate copy a cycle later.
  task automatic chk_en();
    logic [15:0] e;
    e = {~shd[6][8], ~shd[5][4], ~shd[3][2], ~shd[3][3], ~shd[2][10], ~shd[1][3:0],
      ~shd[1][11:8], ~shd[0][3], ~shd[0][1], ~shd[0][0]};
    @(negedge CLOCK);
    chk("enables", e, {dmt, dma, ctmu, refc, cmpr, cmp, cap, spi, can, adc});
    chk("pwm_sent", {~shd[4][10:8], ~shd[6][12:11]}, {pwm, sb, sa});
    chk("sel_out", e & sel_in, sel_out);
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk("clk_gate", e, gate);
    @(posedge CLOCK);
  endtask

  // One write; each channel is released at the edge that takes it.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic at, wt, bt;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bt = 1'b0;
    while (!bt)
    begin
      @(negedge CLOCK);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid && bready;
      if (bt)
        chk("bresp", er, bresp);
      @(posedge CLOCK);
      if (at)
        awvalid <= 1'b0;
      if (wt)
        wvalid <= 1'b0;
      if (bt)
        bready <= 1'b0;
    end
    chk_en();
  endtask

  // One read; data and response are compared on the falling edge before the edge that takes them.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic at, rt;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rt = 1'b0;
    while (!rt)
    begin
      @(negedge CLOCK);
      at = arvalid && arready;
      rt = rvalid && rready;
      if (rt)
        chk("read", {2'b00, er, ed}, {2'b00, rresp, rdata});
      @(posedge CLOCK);
      if (at)
        arvalid <= 1'b0;
      if (rt)
        rready <= 1'b0;
    end
    @(posedge CLOCK);
  endtask

  // Every register reads zero and every unit is enabled out of reset.
  task automatic t_reset();
    foreach (shd[i])
      shd[i] = 16'h0000;
    foreach (ofs[i])
      axi_rd(ofs[i], 32'h0000_0000, PMD_RESP_OKAY);
    chk_en();
    $display("reset test done");
  endtask

  // A single one walks through every bit of every register, then all ones, then zero.
  task automatic t_walk();
    for (int i = 0; i < 7; i++)
    begin
      for (int b = 0; b < 16; b++)
      begin
        shd[i] = (16'h0001 << b) & msk[i];
        axi_wr(ofs[i], 32'h0000_0001 << b, 4'hF, PMD_RESP_OKAY);
        axi_rd(ofs[i], {16'h0000, shd[i]}, PMD_RESP_OKAY);
      end
      shd[i] = msk[i];
      axi_wr(ofs[i], 32'hFFFF_FFFF, 4'hF, PMD_RESP_OKAY);
      axi_rd(ofs[i], {16'h0000, msk[i]}, PMD_RESP_OKAY);
      shd[i] = 16'h0000;
      axi_wr(ofs[i], 32'h0000_0000, 4'hF, PMD_RESP_OKAY);
    end
    $display("walk test done");
  endtask

  // Byte strobes: only the strobed byte lane changes.
  task automatic t_strobe();
    shd[1] = 16'h0F00;
    axi_wr(PMD_OFS_CTRL_2, 32'hFFFF_FFFF, 4'b1110, PMD_RESP_OKAY);
    axi_wr(PMD_OFS_CTRL_2, 32'h0000_0000, 4'b1101, PMD_RESP_OKAY);
    axi_rd(PMD_OFS_CTRL_2, 32'h0000_0F00, PMD_RESP_OKAY);
    $display("strobe test done");
  endtask

  // An unmapped address is refused and leaves the bank untouched.
  task automatic t_unmap();
    sel_in <= 16'h5A5A;
    axi_wr(8'h10, 32'hFFFF_FFFF, 4'hF, PMD_RESP_SLVERR);
    axi_rd(8'h10, 32'h0000_0000, PMD_RESP_SLVERR);
    axi_rd(PMD_OFS_CTRL_2, 32'h0000_0F00, PMD_RESP_OKAY);
    $display("unmapped test done");
  endtask

  // A reset in mid-run clears disables that were set.
  task automatic t_rst2();
    RSTN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    t_reset();
    $display("second reset test done");
  endtask

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge CLOCK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    t_reset();
    t_walk();
    t_strobe();
    t_unmap();
    t_rst2();
    end_sim();
  end

  // Watchdog well beyond the thousand or so cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    num_errors++;
    end_sim();
  end
endmodule
